// ==== cam_indirect_access_ports_tb_top.sv ====
// self-checking testbench for the cam indirect access ports
`timescale 1ns/1ps
module cam_indirect_access_ports_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic upper_half_sel = 1'b0;
  logic [12:0] abs_ptr = 13'h1fff;
  logic [12:0] hh_ptr = 13'h0200;
  logic [12:0] he_ptr = 13'h0100;
  logic hh_low = 1'b0;
  logic he_low = 1'b0;
  ciap_pkg::ciap_stamp_t stamp_cmd = '0;
  logic [2:0] sel2 = 3'h3;
  ciap_pkg::ciap_req_t req;
  logic [15:0] rdata;
  logic [15:0] v;
  logic hh_inc, he_inc, hh_step, he_step, go, as_app, as_stm;
  logic [12:0] st_addr;
  logic step_seen = 1'b0;
  logic step_seen_hh = 1'b0;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;

  // 40 mhz clock
  always #12.5 clk = ~clk;

  ciap_host_model i_ciap_host_model (.clk(clk), .rdata(rdata), .req(req));

  ciap_indirect_ports i_ciap_indirect_ports (
    .clk(clk), .reset(reset), .req(req), .upper_half_sel(upper_half_sel),
    .absolute_pointer(abs_ptr), .hit_pointer(hh_ptr), .hit_end_pointer(he_ptr),
    .hit_ptr_low_access(hh_low), .hit_end_ptr_low_access(he_low), .stamp_cmd(stamp_cmd),
    .stamp2_segment_sel(sel2), .rdata(rdata), .hit_ptr_inc(hh_inc), .hit_end_ptr_inc(he_inc),
    .hit_ptr_entry_step(hh_step), .hit_end_ptr_entry_step(he_step), .stamp_go(go),
    .stamp_addr(st_addr), .append_autoswitch_en(as_app), .stamp_autoswitch_en(as_stm)
  );

  // entry-step pulses captured while a hit-end or hit window read is on the bus
  always @(posedge clk) begin
    if (req.rd === 1'b1 && req.addr === 8'h10) begin
      step_seen <= he_step;
    end
    if (req.rd === 1'b1 && req.addr === 8'h0e) begin
      step_seen_hh <= hh_step;
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard: the sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_ciap_host_model.access(1'b0, a, d, v);
  endtask

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [15:0] e);
    i_ciap_host_model.access(1'b1, a, 16'h0000, v);
    chk(name, v, e);
  endtask

  // one-cycle stamp or pointer-access pulse; packs go, stamp address (when go), hit inc, hit-end inc
  task automatic pulse(input logic [2:0] s, input logic hl, input logic el, input logic [15:0] e);
    @(posedge clk);
    stamp_cmd <= s;
    hh_low <= hl;
    he_low <= el;
    // combinational answers stand until the edge that ends the pulse
    @(posedge clk);
    chk("stamp_inc", {go, go ? st_addr : 13'h0000, hh_inc, he_inc}, e);
    stamp_cmd <= '0;
    hh_low <= 1'b0;
    he_low <= 1'b0;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    // reset values and the unmapped hole
    rd_chk("cfg_low", 8'h12, 16'h0000);
    rd_chk("cfg_high", 8'h13, 16'h0000);
    rd_chk("abs_attr", 8'h14, 16'h0010);
    rd_chk("hit_attr", 8'h16, 16'h0010);
    rd_chk("he_attr", 8'h18, 16'h0010);
    rd_chk("unmapped", 8'h1a, 16'h0000);
    pulse(3'b000, 1'b1, 1'b1, 16'h0003);
    // all high bits set: unused bits stay zero, holds stop increments
    wr(8'h13, 16'hffff);
    rd_chk("cfg_high", 8'h13, 16'h003f);
    chk("autoswitch", {14'h0000, as_app, as_stm}, 16'h0003);
    pulse(3'b000, 1'b1, 1'b1, 16'h0000);
    wr(8'h13, 16'h0004);
    chk("autoswitch", {14'h0000, as_app, as_stm}, 16'h0000);
    // fixed segments 5 and 2, no stepping
    wr(8'h12, 16'h0502);
    rd_chk("cfg_low", 8'h12, 16'ha542);
    pulse(3'b100, 1'b0, 1'b0, 16'h8415);
    pulse(3'b010, 1'b0, 1'b0, 16'h8808);
    // stepping set: single stamps are refused, second form uses the selector
    wr(8'h12, 16'h0d1a);
    pulse(3'b100, 1'b0, 1'b0, 16'h0000);
    pulse(3'b101, 1'b0, 1'b0, 16'h840d);
    pulse(3'b010, 1'b0, 1'b0, 16'h0000);
    pulse(3'b011, 1'b0, 1'b0, 16'h880c);
    // every stepping code on both windows: entry-step pulses and next segments after one access
    for (int m = 0; m < 4; m++) begin
      wr(8'h12, 16'((m << 11) | (m << 3) | 16'h0500));
      i_ciap_host_model.access(1'b1, 8'h10, 16'h0000, v);
      i_ciap_host_model.access(1'b1, 8'h0e, 16'h0000, v);
      chk("entry_step", {14'h0000, step_seen, step_seen_hh}, {14'h0000, m[1], m[1]});
      rd_chk("step_next", 8'h12,
             16'(((5 + m % 2) << 13) | (m << 11) | 16'h0500 | ((m % 2) << 5) | (m << 3)));
    end
    // window halves and pointer plus segment addressing
    wr(8'h12, 16'h0502);
    upper_half_sel <= 1'b1;
    wr(8'h10, 16'hbeef);
    upper_half_sel <= 1'b0;
    wr(8'h10, 16'h1234);
    wr(8'h12, 16'h0602);
    wr(8'h10, 16'h5555);
    he_ptr <= 13'h0101;
    wr(8'h12, 16'h0402);
    rd_chk("he_lower", 8'h10, 16'h1234);
    upper_half_sel <= 1'b1;
    rd_chk("he_upper", 8'h10, 16'hbeef);
    wr(8'h0e, 16'h0f0f);
    hh_ptr <= 13'h0201;
    wr(8'h12, 16'h0401);
    rd_chk("hh_window", 8'h0e, 16'h0f0f);
    // attribute history writes; pointers were loaded beforehand
    // pointers loaded first
    wr(8'h14, 16'hffff);
    rd_chk("abs_attr", 8'h14, 16'h0030);
    wr(8'h16, 16'h0020);
    rd_chk("hit_attr", 8'h16, 16'h0030);
    wr(8'h18, 16'h0020);
    rd_chk("he_attr", 8'h18, 16'h0030);
    wr(8'h18, 16'h0000);
    rd_chk("he_attr", 8'h18, 16'h0010);
    // entry 105h: stamped earlier, then filled through the hit-end window
    he_ptr <= 13'h0105;
    rd_chk("he_attr", 8'h18, 16'h0020);
    wrap_up();
  end
endmodule

// ==== ciap_host_model.sv ====
// host processor model driving the cpu register port of the indirect access block
`timescale 1ns/1ps
module ciap_host_model (
  input wire logic clk,
  input wire logic [15:0] rdata,
  output ciap_pkg::ciap_req_t req
);
  // idle bus at time zero, no request before reset is released
  initial begin
    req = '0;
  end

  // one register cycle: request taken at the next edge, read data taken one edge later
  // no port traffic here
  // the model never runs input or output port traffic, so windows are only used while idle
  task automatic access(input logic rd, input logic [7:0] addr, input logic [15:0] wdata,
                        output logic [15:0] val);
    @(posedge clk);
    req <= '{rd: rd, wr: !rd, addr: addr, wdata: wdata};
    @(posedge clk);
    req <= '0;
    // registered read data stands from the edge after the read until the next read
    @(posedge clk);
    val = rdata;
  endtask
endmodule

// ==== ciap_indirect_ports.sv ====
// module: segment configuration, data windows and attribute windows of the cam
// Overview of operation
// - hit-end window addresses hit-end pointer plus segment
// - window moves one endian-selected 16-bit half
// - segment config is 32 bits at 13h/12h
// - high bit 5 enables append port switch
// - high bit 4 enables stamp port switch
// - bits 3/2 hold pointers during stamp commands
// - bits 1/0 hold general pointer auto-increment
// - low-half pointer access or a stamp triggers increment
// - stepping fields: none, segment, entry, both
// - next-segment fields show upcoming window segment
// - fixed-segment fields used when segment not stepping
// - single hit-end stamp needs step field 00
// - single hit stamp needs step field 00
// - single stamps use fixed segment, second uses sel
// - 14h attributes of absolute pointer entry
// - 16h attributes of hit pointer entry
// - 18h attributes of hit-end pointer entry
// - hit window addresses hit pointer plus segment
// - absolute pointer is a 13-bit input, not reset here
`timescale 1ns/1ps
module ciap_indirect_ports (
  input wire logic clk,
  input wire logic reset,
  input wire ciap_pkg::ciap_req_t req,
  input wire logic upper_half_sel,
  input wire logic [ciap_pkg::addr_w-1:0] absolute_pointer,
  input wire logic [ciap_pkg::addr_w-1:0] hit_pointer,
  input wire logic [ciap_pkg::addr_w-1:0] hit_end_pointer,
  input wire logic hit_ptr_low_access,
  input wire logic hit_end_ptr_low_access,
  input wire ciap_pkg::ciap_stamp_t stamp_cmd,
  input wire logic [2:0] stamp2_segment_sel,
  output logic [15:0] rdata,
  output logic hit_ptr_inc,
  output logic hit_end_ptr_inc,
  output logic hit_ptr_entry_step,
  output logic hit_end_ptr_entry_step,
  output logic stamp_go,
  output logic [ciap_pkg::addr_w-1:0] stamp_addr,
  output logic append_autoswitch_en,
  output logic stamp_autoswitch_en
);
  logic [5:0] high_ff;
  logic [1:0] he_step_ff;
  logic [1:0] hh_step_ff;
  logic [2:0] he_fixed_ff;
  logic [2:0] hh_fixed_ff;
  logic [2:0] he_seg_ff;
  logic [2:0] hh_seg_ff;
  logic [31:0] table_mem [ciap_pkg::entries];
  logic access_hist_mem [ciap_pkg::entries];
  logic empty_mem [ciap_pkg::entries];
  logic [ciap_pkg::addr_w-1:0] he_loc;
  logic [ciap_pkg::addr_w-1:0] hh_loc;
  logic [15:0] low_view;
  logic he_win_acc;
  logic hh_win_acc;
  logic he_stamp_ok;
  logic hh_stamp_ok;
  logic [2:0] he_stamp_seg;
  logic [2:0] hh_stamp_seg;
  logic [15:0] nxt_rdata;
  logic [15:0] rdata_ff;

  // hit-end and hit window locations
  // next segment fields always reflect the upcoming access, so they form the sum
  assign he_loc = hit_end_pointer + ciap_pkg::addr_w'(he_seg_ff);
  assign hh_loc = hit_pointer + ciap_pkg::addr_w'(hh_seg_ff);

  assign he_win_acc = (req.rd | req.wr) && req.addr == ciap_pkg::hit_end_data_window_addr;
  assign hh_win_acc = (req.rd | req.wr) && req.addr == ciap_pkg::hit_data_window_addr;

  assign append_autoswitch_en = high_ff[ciap_pkg::append_autoswitch_bit];
  assign stamp_autoswitch_en = high_ff[ciap_pkg::stamp_autoswitch_bit];

  always_ff @(posedge clk) begin
    if (reset) begin
      high_ff <= ciap_pkg::high_reset;
    end else if (req.wr && req.addr == ciap_pkg::segment_config_high_addr) begin
      high_ff <= req.wdata[5:0];
    end
  end

  // stepping and fixed segment fields of low half
  always_ff @(posedge clk) begin
    if (reset) begin
      he_step_ff <= ciap_pkg::step_reset;
      hh_step_ff <= ciap_pkg::step_reset;
      he_fixed_ff <= ciap_pkg::seg_reset;
      hh_fixed_ff <= ciap_pkg::seg_reset;
    end else if (req.wr && req.addr == ciap_pkg::segment_config_low_addr) begin
      he_step_ff <= req.wdata[ciap_pkg::he_step_lsb +: 2];
      hh_step_ff <= req.wdata[ciap_pkg::hh_step_lsb +: 2];
      he_fixed_ff <= req.wdata[ciap_pkg::he_fixed_lsb +: 3];
      hh_fixed_ff <= req.wdata[ciap_pkg::hh_fixed_lsb +: 3];
    end
  end

  // next segment: load fixed on config write or when not stepping
  // step the segment after each window access when asked
  // segment wraps modulo 8 since the field is three bits wide
  always_ff @(posedge clk) begin
    if (reset) begin
      he_seg_ff <= ciap_pkg::seg_reset;
    end else if (req.wr && req.addr == ciap_pkg::segment_config_low_addr) begin
      he_seg_ff <= req.wdata[ciap_pkg::he_fixed_lsb +: 3];
    end else if (he_win_acc && he_step_ff[0]) begin
      he_seg_ff <= he_seg_ff + 3'h1;
    end else if (!he_step_ff[0]) begin
      he_seg_ff <= he_fixed_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      hh_seg_ff <= ciap_pkg::seg_reset;
    end else if (req.wr && req.addr == ciap_pkg::segment_config_low_addr) begin
      hh_seg_ff <= req.wdata[ciap_pkg::hh_fixed_lsb +: 3];
    end else if (hh_win_acc && hh_step_ff[0]) begin
      hh_seg_ff <= hh_seg_ff + 3'h1;
    end else if (!hh_step_ff[0]) begin
      hh_seg_ff <= hh_fixed_ff;
    end
  end

  // entry stepping requests to the pointer registers
  assign hit_end_ptr_entry_step = he_win_acc && he_step_ff[1];
  assign hit_ptr_entry_step = hh_win_acc && hh_step_ff[1];

  // single hit-end stamp gated by step field
  // single hit stamp gated by step field
  assign he_stamp_ok = stamp_cmd.he && (stamp_cmd.second || he_step_ff == ciap_pkg::ciap_step_none);
  assign hh_stamp_ok = stamp_cmd.hh && (stamp_cmd.second || hh_step_ff == ciap_pkg::ciap_step_none);
  assign stamp_go = he_stamp_ok | hh_stamp_ok;

  assign he_stamp_seg = stamp_cmd.second ? stamp2_segment_sel : he_fixed_ff;
  assign hh_stamp_seg = stamp_cmd.second ? stamp2_segment_sel : hh_fixed_ff;
  assign stamp_addr = he_stamp_ok ? hit_end_pointer + ciap_pkg::addr_w'(he_stamp_seg)
                                  : hit_pointer + ciap_pkg::addr_w'(hh_stamp_seg);

  // increments on low-half pointer access or on a stamp
  // stamp hold bits apply while a stamp runs
  always_comb begin
    hit_end_ptr_inc = hit_end_ptr_low_access && !high_ff[ciap_pkg::he_hold_bit];
    hit_ptr_inc = hit_ptr_low_access && !high_ff[ciap_pkg::hh_hold_bit];
    if (he_stamp_ok && !high_ff[ciap_pkg::stamp_he_hold_bit]) begin
      hit_end_ptr_inc = 1'b1;
    end
    if (hh_stamp_ok && !high_ff[ciap_pkg::stamp_hh_hold_bit]) begin
      hit_ptr_inc = 1'b1;
    end
  end

  // window writes touch one endian-selected half
  // host keeps ports idle, so no arbitration here
  always_ff @(posedge clk) begin
    if (req.wr && he_win_acc) begin
      if (upper_half_sel) begin
        table_mem[he_loc][31:16] <= req.wdata;
      end else begin
        table_mem[he_loc][15:0] <= req.wdata;
      end
    end else if (req.wr && hh_win_acc) begin
      if (upper_half_sel) begin
        table_mem[hh_loc][31:16] <= req.wdata;
      end else begin
        table_mem[hh_loc][15:0] <= req.wdata;
      end
    end
  end

  // access history write, stamp marks history
  // history set means accessed, empty flag cleared on window write
  // table flags have no reset of their own; init covers power-up state only
  always_ff @(posedge clk) begin
    if (req.wr && req.addr == ciap_pkg::absolute_entry_attributes_addr) begin
      access_hist_mem[absolute_pointer] <= req.wdata[ciap_pkg::access_history_pos];
    end else if (req.wr && req.addr == ciap_pkg::hit_entry_attributes_addr) begin
      access_hist_mem[hit_pointer] <= req.wdata[ciap_pkg::access_history_pos];
    end else if (req.wr && req.addr == ciap_pkg::hit_end_entry_attributes_addr) begin
      access_hist_mem[hit_end_pointer] <= req.wdata[ciap_pkg::access_history_pos];
    end
    // a stamp beats a host clear of the same entry in one cycle
    if (stamp_go) begin
      access_hist_mem[stamp_addr] <= 1'b1;
    end
  end

  // empty flag cleared when a window write lands in the entry
  always_ff @(posedge clk) begin
    if (req.wr && he_win_acc) begin
      empty_mem[he_loc] <= 1'b0;
    end else if (req.wr && hh_win_acc) begin
      empty_mem[hh_loc] <= 1'b0;
    end
  end

  initial begin
    for (int i = 0; i < ciap_pkg::entries; i++) begin
      access_hist_mem[i] = ciap_pkg::access_history_reset;
      empty_mem[i] = ciap_pkg::empty_flag_reset;
    end
  end

  // low half image of the segment config
  assign low_view = {he_seg_ff, he_step_ff, he_fixed_ff, hh_seg_ff, hh_step_ff, hh_fixed_ff};

  always_comb begin
    nxt_rdata = 16'h0000;
    unique case (req.addr)
      ciap_pkg::hit_end_data_window_addr: begin
        nxt_rdata = upper_half_sel ? table_mem[he_loc][31:16] : table_mem[he_loc][15:0];
      end
      ciap_pkg::hit_data_window_addr: begin
        nxt_rdata = upper_half_sel ? table_mem[hh_loc][31:16] : table_mem[hh_loc][15:0];
      end
      ciap_pkg::segment_config_low_addr: nxt_rdata = low_view;
      ciap_pkg::segment_config_high_addr: nxt_rdata = {10'h000, high_ff};
      ciap_pkg::absolute_entry_attributes_addr: begin
        nxt_rdata[ciap_pkg::access_history_pos] = access_hist_mem[absolute_pointer];
        nxt_rdata[ciap_pkg::empty_flag_pos] = empty_mem[absolute_pointer];
      end
      ciap_pkg::hit_entry_attributes_addr: begin
        nxt_rdata[ciap_pkg::access_history_pos] = access_hist_mem[hit_pointer];
        nxt_rdata[ciap_pkg::empty_flag_pos] = empty_mem[hit_pointer];
      end
      ciap_pkg::hit_end_entry_attributes_addr: begin
        nxt_rdata[ciap_pkg::access_history_pos] = access_hist_mem[hit_end_pointer];
        nxt_rdata[ciap_pkg::empty_flag_pos] = empty_mem[hit_end_pointer];
      end
      default: nxt_rdata = 16'h0000;
    endcase
  end

  // read data registered; holds until the next read
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_ff <= 16'h0000;
    end else if (req.rd) begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign rdata = rdata_ff;

  // pointer width fixed by port type; pointer values and any reset of them come from outside
  // assertions
  a_high_reset_zero: assert property (@(posedge clk) reset |=> high_ff == 6'h00 && he_step_ff == 2'h0)
    else $error("config not cleared by reset");
  a_stamp1_gate: assert property (@(posedge clk) disable iff (reset)
    (stamp_cmd.he && !stamp_cmd.second && he_step_ff != 2'h0 && !stamp_cmd.hh) |-> !stamp_go)
    else $error("single hit-end stamp ran while stepping");
  a_stamp1_gate_hh: assert property (@(posedge clk) disable iff (reset)
    (stamp_cmd.hh && !stamp_cmd.second && hh_step_ff != 2'h0 && !stamp_cmd.he) |-> !stamp_go)
    else $error("single hit stamp ran while stepping");
  a_stamp2_runs: assert property (@(posedge clk) disable iff (reset)
    (stamp_cmd.second && (stamp_cmd.he || stamp_cmd.hh)) |-> stamp_go)
    else $error("second-form stamp did not run");
  a_inc_low_only: assert property (@(posedge clk) disable iff (reset)
    (!hit_end_ptr_low_access && !stamp_cmd.he) |-> !hit_end_ptr_inc)
    else $error("hit-end pointer increment without low access");
  a_hold_blocks: assert property (@(posedge clk) disable iff (reset)
    (high_ff[1] && !stamp_cmd.he) |-> !hit_end_ptr_inc)
    else $error("hold bit did not stop increment");
  a_seg_steps: assert property (@(posedge clk) disable iff (reset)
    (he_win_acc && he_step_ff[0] && !(req.wr && req.addr == 8'h12)) |=> he_seg_ff == $past(he_seg_ff) + 3'h1)
    else $error("hit-end segment did not step");
  a_seg_fixed: assert property (@(posedge clk) disable iff (reset)
    (!he_step_ff[0] && !(req.wr && req.addr == 8'h12)) ##1 !he_step_ff[0] |-> he_seg_ff == he_fixed_ff)
    else $error("fixed segment not used");
  a_rsvd_zero: assert property (@(posedge clk) disable iff (reset)
    $past(req.rd) && $past(req.addr) == 8'h13 |-> rdata[15:6] == 10'h000)
    else $error("reserved config bits read nonzero");
  a_stamp_hold: assert property (@(posedge clk) disable iff (reset)
    (stamp_cmd.he && stamp_cmd.second && !high_ff[3]) |-> hit_end_ptr_inc)
    else $error("stamp did not increment hit-end pointer");

  // configuration register behaviour
  a_append_sw_write: assert property (@(posedge clk) disable iff (reset)
    (req.wr && req.addr == ciap_pkg::segment_config_high_addr) |=> append_autoswitch_en == $past(req.wdata[5]))
    else $error("append switch enable not loaded");
  a_stamp_sw_write: assert property (@(posedge clk) disable iff (reset)
    (req.wr && req.addr == ciap_pkg::segment_config_high_addr) |=> stamp_autoswitch_en == $past(req.wdata[4]))
    else $error("stamp switch enable not loaded");
  a_high_stable: assert property (@(posedge clk) disable iff (reset)
    !(req.wr && req.addr == ciap_pkg::segment_config_high_addr) |=> $stable(high_ff))
    else $error("high half changed without a write");
  a_cfg_low_load: assert property (@(posedge clk) disable iff (reset)
    (req.wr && req.addr == ciap_pkg::segment_config_low_addr) |=> he_step_ff == $past(req.wdata[12:11])
      && he_seg_ff == $past(req.wdata[10:8]) && hh_seg_ff == $past(req.wdata[2:0]))
    else $error("low half write not loaded");
  a_low_stable: assert property (@(posedge clk) disable iff (reset)
    !(req.wr && req.addr == ciap_pkg::segment_config_low_addr) |=> $stable(he_step_ff) && $stable(hh_step_ff))
    else $error("stepping field changed without a write");
  a_hh_seg_steps: assert property (@(posedge clk) disable iff (reset)
    (hh_win_acc && hh_step_ff[0] && !(req.wr && req.addr == ciap_pkg::segment_config_low_addr))
      |=> hh_seg_ff == $past(hh_seg_ff) + 3'h1)
    else $error("hit segment did not step");
  a_hh_seg_fixed: assert property (@(posedge clk) disable iff (reset)
    (!hh_step_ff[0] && !(req.wr && req.addr == ciap_pkg::segment_config_low_addr)) ##1 !hh_step_ff[0]
      |-> hh_seg_ff == hh_fixed_ff)
    else $error("hit fixed segment not used");
  a_step_idle: assert property (@(posedge clk) disable iff (reset)
    !(req.rd || req.wr) |-> !hit_end_ptr_entry_step && !hit_ptr_entry_step)
    else $error("entry step without window access");

  // hit pointer increment behaviour and second-form stamp segment
  a_hh_low_only: assert property (@(posedge clk) disable iff (reset)
    (!hit_ptr_low_access && !stamp_cmd.hh) |-> !hit_ptr_inc)
    else $error("hit pointer increment without low access");
  a_hh_hold_blocks: assert property (@(posedge clk) disable iff (reset)
    (high_ff[0] && !stamp_cmd.hh) |-> !hit_ptr_inc)
    else $error("hit hold bit did not stop increment");
  a_hh_stamp_hold: assert property (@(posedge clk) disable iff (reset)
    (stamp_cmd.hh && stamp_cmd.second && !stamp_cmd.he && !high_ff[2]) |-> hit_ptr_inc)
    else $error("stamp did not increment hit pointer");
  a_stamp2_seg: assert property (@(posedge clk) disable iff (reset)
    (stamp_cmd.he && stamp_cmd.second) |-> stamp_addr == hit_end_pointer + ciap_pkg::addr_w'(stamp2_segment_sel))
    else $error("second-form stamp used wrong segment");

  // table and attribute behaviour
  a_attr_rsvd_zero: assert property (@(posedge clk) disable iff (reset)
    $past(req.rd) && $past(req.addr) == 8'h14 |-> rdata[15:6] == 10'h000 && rdata[3:0] == 4'h0)
    else $error("reserved attribute bits read nonzero");
  a_hist_write: assert property (@(posedge clk) disable iff (reset)
    (req.wr && req.addr == ciap_pkg::absolute_entry_attributes_addr && !stamp_go)
      |=> access_hist_mem[$past(absolute_pointer)] == $past(req.wdata[5]))
    else $error("access history write lost");
  a_stamp_marks: assert property (@(posedge clk) disable iff (reset)
    stamp_go |=> access_hist_mem[$past(stamp_addr)])
    else $error("stamp did not mark access history");
  a_empty_clear: assert property (@(posedge clk) disable iff (reset)
    (req.wr && he_win_acc) |=> !empty_mem[$past(he_loc)])
    else $error("window write left entry empty");
  a_he_win_upper: assert property (@(posedge clk) disable iff (reset)
    (req.wr && he_win_acc && upper_half_sel) |=> table_mem[$past(he_loc)][31:16] == $past(req.wdata))
    else $error("hit-end window upper write lost");
  a_hh_win_lower: assert property (@(posedge clk) disable iff (reset)
    (req.wr && hh_win_acc && !upper_half_sel) |=> table_mem[$past(hh_loc)][15:0] == $past(req.wdata))
    else $error("hit window lower write lost");
endmodule

// ==== ciap_pkg.sv ====
// package: register map, field layout and types for the cam indirect access ports
package ciap_pkg;
  // register offsets on the 8-bit cpu address
  localparam logic [7:0] hit_data_window_addr = 8'h0e;
  localparam logic [7:0] hit_end_data_window_addr = 8'h10;
  localparam logic [7:0] segment_config_low_addr = 8'h12;
  localparam logic [7:0] segment_config_high_addr = 8'h13;
  localparam logic [7:0] absolute_entry_attributes_addr = 8'h14;
  localparam logic [7:0] hit_entry_attributes_addr = 8'h16;
  localparam logic [7:0] hit_end_entry_attributes_addr = 8'h18;
  // high half fields
  localparam int append_autoswitch_bit = 5;
  localparam int stamp_autoswitch_bit = 4;
  localparam int stamp_he_hold_bit = 3;
  localparam int stamp_hh_hold_bit = 2;
  localparam int he_hold_bit = 1;
  localparam int hh_hold_bit = 0;
  localparam logic [15:0] high_mask = 16'h003f;
  // low half fields
  localparam int he_next_lsb = 13;
  localparam int he_step_lsb = 11;
  localparam int he_fixed_lsb = 8;
  localparam int hh_next_lsb = 5;
  localparam int hh_step_lsb = 3;
  localparam int hh_fixed_lsb = 0;
  // attribute fields
  localparam int access_history_pos = 5;
  localparam int empty_flag_pos = 4;
  localparam logic access_history_reset = 1'b0;
  localparam logic empty_flag_reset = 1'b1;
  // table geometry and reset values
  localparam int addr_w = 13;
  localparam int entries = 8192;
  localparam logic [2:0] seg_reset = 3'h0;
  localparam logic [1:0] step_reset = 2'h0;
  localparam logic [5:0] high_reset = 6'h00;
  localparam logic [addr_w-1:0] ptr_reset = 13'h0000;

  // window stepping modes
  typedef enum logic [1:0] {
    ciap_step_none = 2'b00,
    ciap_step_seg = 2'b01,
    ciap_step_entry = 2'b10,
    ciap_step_both = 2'b11
  } ciap_step_t;

  // cpu port request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [15:0] wdata;
  } ciap_req_t;

  // stamp command request from the command engine
  typedef struct packed {
    logic he;
    logic hh;
    logic second;
  } ciap_stamp_t;
endpackage
